// >>> rtl/kbpi_pkg.sv
// Constants, register map and bus enumerations of the keyboard pin interrupt unit.
// Assumes an AHB-Lite fabric with 32-bit data and one clock, hclk.

`default_nettype none

package kbpi_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int unsigned KBPI_DATA_W   = 32;
    localparam int unsigned KBPI_OFF_W    = 4;
    localparam int unsigned KBPI_WIN_W    = 12;
    localparam int unsigned KBPI_MAX_PINS = 32;

    localparam logic [KBPI_OFF_W-1:0] KBPI_OFF_ENABLE   = 4'h0;
    localparam logic [KBPI_OFF_W-1:0] KBPI_OFF_POLARITY = 4'h4;
    localparam logic [KBPI_OFF_W-1:0] KBPI_OFF_STATUS   = 4'h8;
    localparam logic [KBPI_OFF_W-1:0] KBPI_OFF_SOURCE   = 4'hc;

    localparam logic [KBPI_DATA_W-1:0] KBPI_RST_WORD = 32'h0000_0000;

    // ************************************************************
    // Status/control field positions
    // ************************************************************
    localparam int unsigned KBPI_SC_MODE   = 0;
    localparam int unsigned KBPI_SC_IE     = 1;
    localparam int unsigned KBPI_SC_ACK    = 2;
    localparam int unsigned KBPI_SC_FLAG   = 3;
    localparam int unsigned KBPI_SC_VIEW   = 4;
    localparam int unsigned KBPI_SC_CLEAR  = 5;
    localparam int unsigned KBPI_SC_RSV_LO = 6;

    // ************************************************************
    // AHB-Lite encodings
    // ************************************************************
    localparam logic [1:0] KBPI_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] KBPI_HTRANS_SEQ    = 2'h3;
    localparam logic [2:0] KBPI_HSIZE_WORD    = 3'h2;
    localparam logic       KBPI_HRESP_OKAY    = 1'b0;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ
    } kbpi_bus_state_type;

endpackage

`default_nettype wire

// >>> rtl/kbpi_detect.sv
// Pin qualification, edge detection and edge lockout.
// Assumes the pins are already synchronous to hclk.

`default_nettype none

module kbpi_detect
    import kbpi_pkg::*;
#(
    parameter int unsigned N_PINS = 32
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic [N_PINS-1:0] pin,
    input  wire logic [N_PINS-1:0] polarity,
    input  wire logic [N_PINS-1:0] enable,
    output logic      [N_PINS-1:0] edge_hits,
    output logic      [N_PINS-1:0] level_hits,
    output logic                   any_active
);

    logic [N_PINS-1:0] asserted;
    logic [N_PINS-1:0] prev_reg;
    logic [N_PINS-1:0] edge_raw;
    logic              lock_reg;
    logic              lock_next;

    // ************************************************************
    // Qualification
    // ************************************************************
    assign asserted   = ~(pin ^ polarity);
    assign level_hits = asserted & enable;
    assign any_active = |level_hits;

    // Edge needs the deasserted level sampled one cycle before
    assign edge_raw  = level_hits & ~prev_reg;
    // Lockout keeps a bouncing second key from raising a fresh edge
    assign edge_hits = lock_reg ? '0 : edge_raw;
    assign lock_next = (|edge_hits) | (lock_reg & any_active);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_reg <= '0;
            lock_reg <= 1'b0;
        end else begin
            prev_reg <= asserted;
            lock_reg <= lock_next;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_was_low;
        (edge_hits & $past(asserted)) == '0;
    endsequence

    chk_edge_prev_low: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (|edge_hits) |-> s_was_low)
        else $error("edge reported without prior deasserted sample");

    chk_edge_lockout: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (|edge_hits) ##1 any_active [*1] |-> edge_hits == '0)
        else $error("new edge while enabled pins still asserted");

    chk_lock_release: assert property (
        @(posedge hclk) disable iff (!hresetn)
        lock_reg && !any_active |=> !lock_reg)
        else $error("lockout not released after all pins deasserted");

endmodule

`default_nettype wire

// >>> rtl/kbpi_ahb_slave.sv
// AHB-Lite slave front end: address capture, write strobe, registered read data.
// Assumes one master and hready fed back from this slave's hreadyout.

`default_nettype none

module kbpi_ahb_slave
    import kbpi_pkg::*;
(
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic                   hready,
    input  wire logic [KBPI_DATA_W-1:0] hwdata,
    input  wire logic [KBPI_DATA_W-1:0] rd_data,
    output logic      [KBPI_DATA_W-1:0] hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic                        wr_strobe,
    output logic      [KBPI_OFF_W-1:0]  wr_offset,
    output logic      [KBPI_DATA_W-1:0] wr_word,
    output logic      [KBPI_OFF_W-1:0]  rd_offset
);

    kbpi_bus_state_type          state_reg;
    kbpi_bus_state_type          state_next;
    logic [KBPI_OFF_W-1:0]       addr_reg;
    logic                        hit_reg;
    logic [KBPI_DATA_W-1:0]      hrdata_reg;
    logic                        hreadyout_reg;
    logic                        active_trans;
    logic                        accept;
    logic                        hit;

    assign active_trans = (htrans == KBPI_HTRANS_NONSEQ) || (htrans == KBPI_HTRANS_SEQ);
    assign accept       = hsel && active_trans && hready;
    // Unmapped or sub-word accesses read zero and write nothing
    assign hit          = (haddr[KBPI_WIN_W-1:KBPI_OFF_W] == '0) && (hsize == KBPI_HSIZE_WORD);

    always_comb begin
        case (state_reg)
            BUS_READ: state_next = BUS_IDLE;
            BUS_IDLE,
            BUS_WRITE: state_next = accept ? (hwrite ? BUS_WRITE : BUS_READ) : BUS_IDLE;
            default:  state_next = BUS_IDLE;
        endcase
    end

    // One wait state on reads so a write just before is already visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg     <= BUS_IDLE;
            addr_reg      <= '0;
            hit_reg       <= 1'b0;
            hrdata_reg    <= KBPI_RST_WORD;
            hreadyout_reg <= 1'b1;
        end else begin
            state_reg     <= state_next;
            hreadyout_reg <= (state_next != BUS_READ);
            if (accept) begin
                addr_reg <= haddr[KBPI_OFF_W-1:0];
                hit_reg  <= hit;
            end
            if (state_reg == BUS_READ) begin
                hrdata_reg <= hit_reg ? rd_data : KBPI_RST_WORD;
            end
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp     = KBPI_HRESP_OKAY;
    assign wr_strobe = (state_reg == BUS_WRITE) && hit_reg;
    assign wr_offset = addr_reg;
    assign wr_word   = hwdata;
    assign rd_offset = addr_reg;

endmodule

`default_nettype wire

// >>> rtl/kbpi_top.sv
// Keyboard pin interrupt unit: register bank, flag, source capture and request.
// Assumes pins synchronous to hclk and an AHB-Lite master on the same clock.

`default_nettype none

module kbpi_top
    import kbpi_pkg::*;
#(
    parameter int unsigned N_PINS = 32
) (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic                   hready,
    input  wire logic [KBPI_DATA_W-1:0] hwdata,
    output logic      [KBPI_DATA_W-1:0] hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire logic [N_PINS-1:0]      keyboard_input_pin,
    output logic                        irq,
    output logic                        wake_req
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [KBPI_DATA_W-1:0] widen(input logic [N_PINS-1:0] v);
        logic [KBPI_DATA_W-1:0] r;
        r = '0;
        r[N_PINS-1:0] = v;
        return r;
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    logic                   wr_strobe;
    logic [KBPI_OFF_W-1:0]  wr_offset;
    logic [KBPI_DATA_W-1:0] wr_word;
    logic [KBPI_OFF_W-1:0]  rd_offset;
    logic [KBPI_DATA_W-1:0] rd_data;
    logic [KBPI_DATA_W-1:0] hrdata_slv;
    logic                   hreadyout_slv;
    logic                   hresp_slv;

    logic [N_PINS-1:0]      pin_interrupt_mask_reg;
    logic [N_PINS-1:0]      pin_interrupt_mask_next;
    logic [N_PINS-1:0]      polarity_choice_reg;
    logic [N_PINS-1:0]      polarity_choice_next;
    logic                   detection_mode_reg;
    logic                   detection_mode_next;
    logic                   interrupt_enable_bit_reg;
    logic                   interrupt_enable_bit_next;
    logic                   source_latched_view_reg;
    logic                   source_latched_view_next;
    logic                   interrupt_flag_reg;
    logic                   interrupt_flag_next;
    logic [N_PINS-1:0]      source_pin_bits_reg;
    logic [N_PINS-1:0]      source_pin_bits_next;
    logic [N_PINS-1:0]      source_latch_reg;
    logic [N_PINS-1:0]      source_latch_next;
    logic                   irq_reg;
    logic                   wake_reg;

    logic                   wr_enable;
    logic                   wr_polarity;
    logic                   wr_status;
    logic                   flag_acknowledge;
    logic                   source_clear;
    logic [N_PINS-1:0]      edge_hits;
    logic [N_PINS-1:0]      level_hits;
    logic                   any_active;
    logic [N_PINS-1:0]      pin_hits;
    logic                   edge_valid;
    logic                   flag_set;
    logic                   flag_clear;
    logic                   flag_rise;
    logic [KBPI_DATA_W-1:0] status_word;
    logic [N_PINS-1:0]      source_view;

    // ************************************************************
    // Bus front end
    // ************************************************************
    kbpi_ahb_slave u_slave (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .rd_data   (rd_data),
        .hrdata    (hrdata_slv),
        .hreadyout (hreadyout_slv),
        .hresp     (hresp_slv),
        .wr_strobe (wr_strobe),
        .wr_offset (wr_offset),
        .wr_word   (wr_word),
        .rd_offset (rd_offset)
    );

    assign hrdata    = hrdata_slv;
    assign hreadyout = hreadyout_slv;
    assign hresp     = hresp_slv;

    // ************************************************************
    // Pin detection
    // ************************************************************
    kbpi_detect #(
        .N_PINS (N_PINS)
    ) u_detect (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pin        (keyboard_input_pin),
        .polarity   (polarity_choice_reg),
        .enable     (pin_interrupt_mask_reg),
        .edge_hits  (edge_hits),
        .level_hits (level_hits),
        .any_active (any_active)
    );

    // ************************************************************
    // Write decode
    // ************************************************************
    assign wr_enable   = wr_strobe && (wr_offset == KBPI_OFF_ENABLE);
    assign wr_polarity = wr_strobe && (wr_offset == KBPI_OFF_POLARITY);
    assign wr_status   = wr_strobe && (wr_offset == KBPI_OFF_STATUS);
    // Command bits act only as pulses and are never stored
    assign flag_acknowledge = wr_status && wr_word[KBPI_SC_ACK];
    assign source_clear     = wr_status && wr_word[KBPI_SC_CLEAR];

    assign pin_interrupt_mask_next   = wr_enable ? wr_word[N_PINS-1:0]
                                                 : pin_interrupt_mask_reg;
    assign polarity_choice_next      = wr_polarity ? wr_word[N_PINS-1:0]
                                                   : polarity_choice_reg;
    assign detection_mode_next       = wr_status ? wr_word[KBPI_SC_MODE]
                                                 : detection_mode_reg;
    assign interrupt_enable_bit_next = wr_status ? wr_word[KBPI_SC_IE]
                                                 : interrupt_enable_bit_reg;
    assign source_latched_view_next  = wr_status ? wr_word[KBPI_SC_VIEW]
                                                 : source_latched_view_reg;

    // ************************************************************
    // Flag and source capture
    // ************************************************************
    assign edge_valid = |edge_hits;
    assign pin_hits   = edge_hits | (detection_mode_reg ? level_hits : '0);
    assign flag_set   = edge_valid || (detection_mode_reg && any_active);
    // Level mode refuses the acknowledge while any enabled pin is held
    assign flag_clear = flag_acknowledge && (!detection_mode_reg || !any_active);
    // Set wins over clear so an event in the acknowledge cycle survives
    assign interrupt_flag_next = flag_set || (interrupt_flag_reg && !flag_clear);
    assign flag_rise  = flag_set && !interrupt_flag_reg;

    assign source_pin_bits_next = pin_hits
                                | (source_clear ? '0 : source_pin_bits_reg);
    assign source_latch_next    = flag_rise    ? source_pin_bits_next :
                                  source_clear ? '0 : source_latch_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_interrupt_mask_reg   <= '0;
            polarity_choice_reg      <= '0;
            detection_mode_reg       <= 1'b0;
            interrupt_enable_bit_reg <= 1'b0;
            source_latched_view_reg  <= 1'b0;
            interrupt_flag_reg       <= 1'b0;
            source_pin_bits_reg      <= '0;
            source_latch_reg         <= '0;
        end else begin
            pin_interrupt_mask_reg   <= pin_interrupt_mask_next;
            polarity_choice_reg      <= polarity_choice_next;
            detection_mode_reg       <= detection_mode_next;
            interrupt_enable_bit_reg <= interrupt_enable_bit_next;
            source_latched_view_reg  <= source_latched_view_next;
            interrupt_flag_reg       <= interrupt_flag_next;
            source_pin_bits_reg      <= source_pin_bits_next;
            source_latch_reg         <= source_latch_next;
        end
    end

    // ************************************************************
    // Request and wake outputs
    // ************************************************************
    // Wake follows the masked flag; the unit has no clock-free path, so
    // stop mode needs hclk kept running to this block by the clock gate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_reg  <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            irq_reg  <= interrupt_flag_next && interrupt_enable_bit_next;
            wake_reg <= interrupt_flag_next && interrupt_enable_bit_next;
        end
    end

    assign irq      = irq_reg;
    assign wake_req = wake_reg;

    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb begin
        status_word = KBPI_RST_WORD;
        status_word[KBPI_SC_MODE] = detection_mode_reg;
        status_word[KBPI_SC_IE]   = interrupt_enable_bit_reg;
        status_word[KBPI_SC_FLAG] = interrupt_flag_reg;
        status_word[KBPI_SC_VIEW] = source_latched_view_reg;
    end

    assign source_view = source_latched_view_reg ? source_latch_reg
                                                 : source_pin_bits_reg;

    assign rd_data = (rd_offset == KBPI_OFF_ENABLE)   ? widen(pin_interrupt_mask_reg) :
                     (rd_offset == KBPI_OFF_POLARITY) ? widen(polarity_choice_reg)    :
                     (rd_offset == KBPI_OFF_STATUS)   ? status_word                   :
                     (rd_offset == KBPI_OFF_SOURCE)   ? widen(source_view)            :
                                                        KBPI_RST_WORD;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_ack_edge_mode;
        flag_acknowledge && !detection_mode_reg && !flag_set;
    endsequence

    sequence s_ack_held_level;
        flag_acknowledge && detection_mode_reg && any_active;
    endsequence

    chk_irq_and_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        irq == (interrupt_flag_reg && interrupt_enable_bit_reg))
        else $error("irq differs from flag and enable");

    chk_flag_on_edge: assert property (
        @(posedge hclk) disable iff (!hresetn)
        edge_valid |=> interrupt_flag_reg)
        else $error("valid edge did not set the flag");

    chk_ack_clears_flag: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_ack_edge_mode |=> !interrupt_flag_reg && !irq)
        else $error("acknowledge did not clear flag in edge mode");

    chk_ack_held_level: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_ack_held_level |=> interrupt_flag_reg)
        else $error("flag cleared while an enabled pin is asserted");

    chk_flag_only_hw: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(interrupt_flag_reg) |-> $past(flag_set))
        else $error("flag set without a detected request");

    chk_source_sticky: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ((($past(source_pin_bits_reg) & ~source_pin_bits_reg) != '0))
            |-> $past(source_clear))
        else $error("source bit fell without a clear command");

    chk_pin_excluded: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ##1 ((source_pin_bits_reg & ~$past(source_pin_bits_reg)
              & ~$past(pin_interrupt_mask_reg)) == '0))
        else $error("disabled pin set a source bit");

    chk_sc_reserved: assert property (
        @(posedge hclk) disable iff (!hresetn)
        status_word[KBPI_DATA_W-1:KBPI_SC_VIEW+1] == '0)
        else $error("reserved or clear bit reads nonzero");

    chk_latched_view: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(interrupt_flag_reg) |-> source_latch_reg == source_pin_bits_reg)
        else $error("latched source not captured at flag set");

endmodule

`default_nettype wire

// >>> testbench/kbpi_keys.sv
// Switch model for the key pins.
// Assumes the bench changes requested levels right after a rising edge.
`default_nettype none
// ****************
// Key switches
// ****************
module kbpi_keys (
    input  wire logic        hclk,
    input  wire logic [31:0] press,
    output logic      [31:0] keyboard_input_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Each level lasts whole cycles, so every edge is seen over two samples
    always_ff @(posedge hclk) begin
        keyboard_input_pin <= press;
    end
endmodule
`default_nettype wire

// >>> testbench/kbpi_tb_top.sv
// Bench for the keyboard pin interrupt unit: AHB-Lite tasks and scenarios.
// Assumes hready fed back from hreadyout and the switch model on the pins.
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
// ****************
// Bench top
// ****************
module kbpi_tb_top
    import kbpi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] OE = KBPI_OFF_ENABLE;
    localparam logic [3:0] OP = KBPI_OFF_POLARITY;
    localparam logic [3:0] OS = KBPI_OFF_STATUS;
    localparam logic [3:0] OC = KBPI_OFF_SOURCE;
    logic        hclk, hresetn, hsel, hwrite;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, press, q;
    wire logic [31:0] hrdata, pins;
    wire logic        hreadyout, hresp, irq, wake_req;
    int          mismatches, checks, cyc;
    kbpi_top #(.N_PINS(32)) kbpi_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .keyboard_input_pin(pins), .irq(irq), .wake_req(wake_req));
    kbpi_keys kbpi_keys_inst (.hclk(hclk), .press(press), .keyboard_input_pin(pins));
    task wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Address phase held until hready, then data phase until hready again
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= KBPI_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= KBPI_HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task wr(input logic [3:0] o, input logic [31:0] d);
        xfer(1'b1, {28'h0, o}, d);
    endtask
    task rd(input logic [3:0] o, input logic [31:0] e, input string nm);
        xfer(1'b0, {28'h0, o}, 32'h0);
        `CHK(nm, e, q)
    endtask
    task hit(input logic [31:0] v);
        @(posedge hclk);
        press <= v;
        repeat (4) @(posedge hclk);
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // A hang is cut short well beyond the few hundred cycles the run needs
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata, press} = '0;
        {mismatches, checks, cyc} = '0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OE, 32'h0, "enable");
        rd(OP, 32'h0, "polarity");
        rd(OS, 32'h0, "status");
        rd(OC, 32'h0, "source");
        `CHK("hresp", 1'b0, hresp)
        wr(OE, 32'h0000_0003);
        wr(OP, 32'h0000_0003);
        rd(OE, 32'h0000_0003, "enable");
        rd(OP, 32'h0000_0003, "polarity");
        xfer(1'b0, 32'h0000_0010, 32'h0);
        `CHK("unmapped", 32'h0, q)
        wr(OS, 32'hffff_ffff);
        rd(OS, 32'h0000_0013, "status");
        wr(OS, 32'h0000_0002);
        hit(32'h1);
        `CHK("irq", 1'b1, irq)
        `CHK("wake", 1'b1, wake_req)
        rd(OS, 32'h0000_000a, "status");
        // Second pin fires while the flag stands, so the latch keeps the first
        hit(32'h0);
        hit(32'h2);
        wr(OS, 32'h0000_0012);
        rd(OC, 32'h0000_0001, "latched");
        wr(OS, 32'h0000_0002);
        rd(OC, 32'h0000_0003, "live");
        wr(OS, 32'h0000_0006);
        rd(OS, 32'h0000_0002, "status");
        `CHK("irq", 1'b0, irq)
        wr(OS, 32'h0000_0000);
        hit(32'h0);
        hit(32'h1);
        `CHK("irq", 1'b0, irq)
        rd(OS, 32'h0000_0008, "status");
        wr(OS, 32'h0000_0005);
        rd(OS, 32'h0000_0009, "status");
        hit(32'h0);
        wr(OS, 32'h0000_0005);
        rd(OS, 32'h0000_0001, "status");
        wr(OS, 32'h0000_0020);
        rd(OC, 32'h0000_0000, "source");
        // Falling edge on a polarity-0 pin, then a rise held off by the lockout
        hit(32'h4);
        wr(OE, 32'h0000_0004);
        hit(32'h0);
        rd(OS, 32'h0000_0008, "status");
        rd(OC, 32'h0000_0004, "source");
        wr(OS, 32'h0000_0004);
        wr(OE, 32'h0000_0005);
        hit(32'h1);
        rd(OS, 32'h0000_0000, "status");
        rd(OC, 32'h0000_0004, "source");
        // Reset in mid-run must drop the sticky source bits and the enables
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OC, 32'h0, "source");
        rd(OE, 32'h0, "enable");
        wrap_up();
    end
endmodule
`undef CHK
`default_nettype wire
